// ---- sam_pkg.sv ----
// Purpose: Constants and types for the source address match result block.
// Assumes: Byte-wide register indices; byte address is four times the index.
// Notes: Table, enables and local data share one byte array, see sam_match.
// Notes on behaviour
// - Index byte holds lowest set mask bit position, or 0x3f without match.
// - Index bit 5 is clear for short match, set for extended match.
// - Index bit 6 shows auto pending conditions only, ignoring strobes and forcing.
// - A 24-bit match mask spans three consecutive bytes, one bit per short entry.
// - Short entry n matches on equal PAN and short words: sets bit n.
// - Extended entry n match sets mask bits 2n and 2n+1.
// - Each 8-byte slot from 0x380 holds two short entries or one extended.
// - Extended entry n pending enable is bit 2n; odd bits are ignored.
package sam_pkg;
   localparam int          NUM_SHORT      = 24;
   localparam int          NUM_EXT        = 12;
   localparam logic [10:0] IDX_TABLE      = 11'h380;
   localparam logic [10:0] IDX_MASK0      = 11'h3e0;
   localparam logic [10:0] IDX_MASK1      = 11'h3e1;
   localparam logic [10:0] IDX_MASK2      = 11'h3e2;
   localparam logic [10:0] IDX_INDEX      = 11'h3e3;
   localparam logic [10:0] IDX_EXT_PEND0  = 11'h3e4;
   localparam logic [10:0] IDX_SHORT_PEND0 = 11'h3e7;
   localparam logic [10:0] IDX_CTRL       = 11'h400;
   localparam logic [6:0]  MEM_BYTES      = 7'h7f;
   localparam logic [7:0]  INDEX_NONE     = 8'h3f;
   localparam logic [23:0] MASK_RESET     = 24'h000000;
   localparam logic [7:0]  MEM_RESET      = 8'h00;
   localparam int          BIT_EXT        = 5;
   localparam int          BIT_PEND       = 6;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Source address of one received frame, offered with a one-cycle strobe.
   typedef struct packed {
      logic        is_ext;
      logic [15:0] pan;
      logic [15:0] short_addr;
      logic [63:0] ext_addr;
   } sam_src_t;

   // Outcome of the most recent match.
   typedef struct packed {
      logic [23:0] bits;
      logic [7:0]  index;
   } sam_result_t;
endpackage

// ---- sam_match.sv ----
// Purpose: Source address matching with result mask and index, AXI4-Lite registers.
// Assumes: One frame source at most per cycle; single outstanding read and write.
// Assumes: Table writes and a frame in one cycle see the old table contents.
// Notes: Result bytes are read only; writes to them are accepted and dropped.
// Notes: An empty slot holds zeros, so an all-zero source address matches it.
// Notes: Software should clear unused slots to a value no frame carries.
`timescale 1ns/10ps
module sam_match
   import sam_pkg::*;
(
   input  wire logic        clk_i,           // Device clock, 250 MHz.
   input  wire logic        rstn_i,          // Asynchronous reset, active low.
   input  wire logic [12:0] s_axi_awaddr,    // Write address.
   input  wire logic        s_axi_awvalid,   // Write address valid.
   output      logic        s_axi_awready,   // Write address ready.
   input  wire logic [31:0] s_axi_wdata,     // Write data.
   input  wire logic [3:0]  s_axi_wstrb,     // Write byte enables.
   input  wire logic        s_axi_wvalid,    // Write data valid.
   output      logic        s_axi_wready,    // Write data ready.
   output      logic [1:0]  s_axi_bresp,     // Write response.
   output      logic        s_axi_bvalid,    // Write response valid.
   input  wire logic        s_axi_bready,    // Write response ready.
   input  wire logic [12:0] s_axi_araddr,    // Read address.
   input  wire logic        s_axi_arvalid,   // Read address valid.
   output      logic        s_axi_arready,   // Read address ready.
   output      logic [31:0] s_axi_rdata,     // Read data.
   output      logic [1:0]  s_axi_rresp,     // Read response.
   output      logic        s_axi_rvalid,    // Read data valid.
   input  wire logic        s_axi_rready,    // Read data ready.
   input  wire logic        src_valid_i,     // One-cycle strobe: source address present.
   input  wire sam_src_t    src_i,           // Received source address.
   output      sam_result_t result_o,        // Match mask and index byte.
   output      logic        result_valid_o   // One-cycle pulse: result updated.
);
   // Table slots, pending enables and local data share one byte array.
   logic [7:0]  mem [0:127];
   // Control and result state.
   logic        auto_pend_enable;
   logic [23:0] match_bits;
   logic [7:0]  match_index;
   // Write channel holding registers.
   logic [10:0] aw_idx;
   logic [7:0]  w_byte;
   logic        w_en;
   logic        aw_held;
   logic        w_held;
   // Combinational match terms for the frame on src_i.
   logic [23:0] next_bits;
   logic [23:0] short_pend;
   logic [23:0] ext_pend;
   logic [23:0] hit_short;
   logic [23:0] hit_ext;
   logic [7:0]  next_index;
   // Read index, decoded straight from the address bus.
   logic [10:0] ar_idx;

   // Pending enable masks live in the byte array, least significant byte first.
   // Odd bits of the extended mask are stored but never looked at.
   assign ext_pend   = {mem[IDX_EXT_PEND0[6:0] + 7'h2], mem[IDX_EXT_PEND0[6:0] + 7'h1],
                        mem[IDX_EXT_PEND0[6:0]]};
   assign short_pend = {mem[IDX_SHORT_PEND0[6:0] + 7'h2], mem[IDX_SHORT_PEND0[6:0] + 7'h1],
                        mem[IDX_SHORT_PEND0[6:0]]};

   // Per-entry comparators; each slot is checked in both forms, the frame picks one.
   // All compares are done in one cycle; area is traded for a fixed one-cycle answer.
   for (genvar n = 0; n < NUM_SHORT; n++) begin : g_entry
      localparam int B = 4 * n;
      assign hit_short[n] = ({mem[B + 1], mem[B]} == src_i.pan) &&
                            ({mem[B + 3], mem[B + 2]} == src_i.short_addr);
      // Extended entry n/2 is read whole for both of its short positions.
      // shared slot storage
      assign hit_ext[n] = ({mem[8 * (n / 2) + 7], mem[8 * (n / 2) + 6],
                            mem[8 * (n / 2) + 5], mem[8 * (n / 2) + 4],
                            mem[8 * (n / 2) + 3], mem[8 * (n / 2) + 2],
                            mem[8 * (n / 2) + 1], mem[8 * (n / 2)]} == src_i.ext_addr);
   end

   // Only the form that the frame carries is reported; the other set is ignored.
   assign next_bits = src_i.is_ext ? hit_ext : hit_short;

   // Lowest set bit and its flags; the pending bit does not look at any ack strobe.
   always_comb begin
      next_index = INDEX_NONE;
      // Scanning from the top down leaves the lowest set bit as the last one written.
      for (int i = NUM_SHORT - 1; i >= 0; i--) begin
         if (next_bits[i]) begin
            next_index = {3'h0, 5'(i)};
            next_index[BIT_EXT] = src_i.is_ext;
            next_index[BIT_PEND] = auto_pend_enable &&
                                   (src_i.is_ext ? ext_pend[i & ~1] : short_pend[i]);
         end
      end
   end

   // Result registers hold the last outcome until the next frame source arrives.
   // A frame with no hit still updates them, so stale matches never linger.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         match_bits     <= MASK_RESET;
         match_index    <= INDEX_NONE;
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= src_valid_i;
         if (src_valid_i) begin
            match_bits  <= next_bits;
            match_index <= next_index;
         end
      end
   end

   // The result port shows the registered outcome with no further logic.
   assign result_o.bits  = match_bits;
   assign result_o.index = match_index;

   // Address and data are caught in either order; the write happens once both are held.
   // Both readies stay low while a response waits, which keeps one write in flight.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_idx  <= 11'h000;
         w_byte  <= 8'h00;
         w_en    <= 1'b0;
      end else begin
         if (aw_held && w_held) begin
            // Both halves are held: the store happens at this edge, so free both.
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_held <= 1'b1;
               aw_idx  <= s_axi_awaddr[12:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_held <= 1'b1;
               w_byte <= s_axi_wdata[7:0];
               w_en   <= s_axi_wstrb[0];
            end
         end
      end
   end

   // Only one write is in flight at a time, so the response needs no queue.
   // Write response; an index outside the byte array and control word is refused.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (aw_held && w_held) begin
         s_axi_bvalid <= 1'b1;
         // The table window, result bytes included, and the control word are the only indices answered OKAY.
         s_axi_bresp  <= (aw_idx[10:7] == IDX_TABLE[10:7] || aw_idx == IDX_CTRL) ?
                         RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // A write to a mapped index whose lowest byte strobe is clear is answered OKAY and changes nothing.
   // Byte array; result bytes are kept out so software cannot fake a match.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // Every byte clears, so the table starts with all slots at zero.
         for (int i = 0; i <= int'(MEM_BYTES); i++) begin
            mem[i] <= MEM_RESET;
         end
      end else if (aw_held && w_held && w_en && aw_idx[10:7] == IDX_TABLE[10:7] &&
                   (aw_idx < IDX_MASK0 || aw_idx > IDX_INDEX)) begin
         mem[aw_idx[6:0]] <= w_byte;
      end
   end

   // Control word: bit 0 allows the automatic pending indication.
   // It resets to 0, so no pending indication shows until software allows it.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         auto_pend_enable <= 1'b0;
      end else if (aw_held && w_held && w_en && aw_idx == IDX_CTRL) begin
         auto_pend_enable <= w_byte[0];
      end
   end

   // Read channel answers one cycle after the address is taken.
   // A new address is refused while the previous answer still waits for rready.
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_idx        = s_axi_araddr[12:2];

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         // Result bytes come from the match registers; the array copies are never read.
         if (ar_idx == IDX_MASK0) begin
            s_axi_rdata <= {24'h000000, match_bits[7:0]};
         end else if (ar_idx == IDX_MASK1) begin
            s_axi_rdata <= {24'h000000, match_bits[15:8]};
         end else if (ar_idx == IDX_MASK2) begin
            s_axi_rdata <= {24'h000000, match_bits[23:16]};
         end else if (ar_idx == IDX_INDEX) begin
            s_axi_rdata <= {24'h000000, match_index};
         end else if (ar_idx[10:7] == IDX_TABLE[10:7]) begin
            s_axi_rdata <= {24'h000000, mem[ar_idx[6:0]]};
         end else if (ar_idx == IDX_CTRL) begin
            s_axi_rdata <= {31'h00000000, auto_pend_enable};
         end else begin
            // Unmapped index: data reads as zero and the response flags the error.
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- sam_match_properties.sv ----
// Purpose: Concurrent checks on the match port and write response of sam_match.
// Assumes: One clock domain; only top-level ports are watched.
// Notes: Result relations are checked in the cycle of the result pulse.
`timescale 1ns/10ps
module sam_match_chk
   import sam_pkg::*;
(
   input wire logic        clk_i,          // Device clock.
   input wire logic        rstn_i,         // Reset, active low.
   input wire logic        src_valid_i,    // Source strobe.
   input wire sam_src_t    src_i,          // Source address.
   input wire sam_result_t result_o,       // Mask and index.
   input wire logic        result_valid_o, // Result pulse.
   input wire logic        s_axi_bvalid,   // Write response valid.
   input wire logic        s_axi_bready,   // Write response ready.
   input wire logic [1:0]  s_axi_bresp     // Write response.
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Mask bits below the reported position; all must be clear.
   logic [23:0] below;
   assign below = result_o.bits & ((24'h000001 << result_o.index[4:0]) - 24'h000001);
   chk_pulse_follows: assert property (src_valid_i |=> result_valid_o)
      else $error("result pulse missing after source strobe");
   chk_result_quiet: assert property (
      !src_valid_i |=> !result_valid_o && $stable(result_o))
      else $error("result changed without source strobe");
   chk_none_index: assert property (
      result_valid_o && result_o.bits == 24'h000000 |-> result_o.index == INDEX_NONE)
      else $error("index not 3f without match");
   chk_lowest_bit: assert property (
      result_valid_o && result_o.bits != 24'h000000 |->
      result_o.index[4:0] < 5'h18 && result_o.bits[result_o.index[4:0]] &&
      below == 24'h000000 && !result_o.index[7])
      else $error("index is not lowest mask bit");
   chk_kind_bit: assert property (
      result_valid_o && result_o.bits != 24'h000000 |->
      result_o.index[5] == $past(src_i.is_ext))
      else $error("index kind bit wrong");
   chk_ext_pair: assert property (
      result_valid_o && result_o.bits != 24'h000000 && result_o.index[5] |->
      !result_o.index[0] && result_o.bits[result_o.index[4:0] + 5'h01])
      else $error("extended match not a bit pair");
   chk_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_bresp_ends: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule
bind sam_match sam_match_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .src_valid_i(src_valid_i),
   .src_i(src_i), .result_o(result_o), .result_valid_o(result_valid_o),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

// ---- tb.sv ----
// Purpose: Self-checking bench for sam_match over AXI4-Lite and the match port.
// Assumes: The result is seen one cycle after the strobe; bus answers are awaited.
// Notes: Table holds short entries 5 and 9 and extended entry 3; the rest stays zero.
`timescale 1ns/10ps
module tb;
   import sam_pkg::*;
   localparam logic [63:0] EXT = 64'h0123456789abcdef;
   logic        clk_i = 1'b0, rstn_i = 1'b0, src_valid_i = 1'b0;
   logic [12:0] s_axi_awaddr = 13'h0000, s_axi_araddr = 13'h0000;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        result_valid_o;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   sam_src_t    src_i = '0;
   sam_result_t result_o;
   int          err_total = 0, n_compared = 0;
   always #2 clk_i = ~clk_i;
   sam_match dut (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .src_valid_i(src_valid_i), .src_i(src_i),
      .result_o(result_o), .result_valid_o(result_valid_o));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Address and data go out together; each is dropped once taken.
   task automatic wr(input logic [10:0] idx, input logic [7:0] d, input logic [1:0] er,
                     input logic [3:0] st);
      logic a, w, b;
      a = 1'b1;
      w = 1'b1;
      b = 1'b1;
      @(posedge clk_i);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (a || w || b) begin
         @(posedge clk_i);
         if (b && s_axi_bvalid) chk({30'h0, s_axi_bresp}, {30'h0, er});
         a = a && !s_axi_awready;
         w = w && !s_axi_wready;
         b = b && !s_axi_bvalid;
         s_axi_awvalid <= a;
         s_axi_wvalid <= w;
         s_axi_bready <= b;
      end
   endtask
   task automatic rd(input logic [10:0] idx, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk_i);
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask
   // The result is looked at in the single cycle that the pulse stands.
   task automatic frame(input logic e, input logic [63:0] x, input logic [31:0] exp);
      @(posedge clk_i);
      src_valid_i <= 1'b1;
      src_i <= '{is_ext: e, pan: 16'h1234, short_addr: 16'habcd, ext_addr: x};
      @(posedge clk_i);
      src_valid_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, result_valid_o}, 32'h1);
      chk(result_o, exp);
      $display("Frame test done, expected %h", exp);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd(IDX_INDEX, 32'h3f, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         wr(11'h394 + 11'(i), 8'(32'habcd1234 >> (8 * i)), RESP_OKAY, 4'hf);
         wr(11'h3a4 + 11'(i), 8'(32'habcd1234 >> (8 * i)), RESP_OKAY, 4'hf);
      end
      for (int i = 0; i < 8; i++) begin
         wr(11'h398 + 11'(i), EXT[i*8 +: 8], RESP_OKAY, 4'hf);
      end
      frame(1'b0, 64'h0, {24'h000220, 8'h05});
      wr(IDX_CTRL, 8'h01, RESP_OKAY, 4'hf);
      rd(IDX_CTRL, 32'h1, RESP_OKAY);
      wr(IDX_EXT_PEND0, 8'h80, RESP_OKAY, 4'hf);
      frame(1'b1, EXT, {24'h0000c0, 8'h26});
      wr(IDX_EXT_PEND0, 8'h40, RESP_OKAY, 4'hf);
      frame(1'b1, EXT, {24'h0000c0, 8'h66});
      wr(IDX_SHORT_PEND0, 8'h20, RESP_OKAY, 4'hf);
      frame(1'b0, 64'h0, {24'h000220, 8'h45});
      wr(IDX_MASK0, 8'hff, RESP_OKAY, 4'hf);
      rd(IDX_MASK0, 32'h20, RESP_OKAY);
      rd(IDX_MASK1, 32'h02, RESP_OKAY);
      rd(IDX_MASK2, 32'h00, RESP_OKAY);
      rd(IDX_INDEX, 32'h45, RESP_OKAY);
      wr(IDX_CTRL, 8'h00, RESP_OKAY, 4'hf);
      frame(1'b0, 64'h0, {24'h000220, 8'h05});
      wr(IDX_SHORT_PEND0 + 11'h1, 8'hff, RESP_OKAY, 4'h0);
      rd(IDX_SHORT_PEND0 + 11'h1, 32'h0, RESP_OKAY);
      rd(11'h7ff, 32'h0, RESP_SLVERR);
      wr(11'h7ff, 8'h00, RESP_SLVERR, 4'hf);
      frame(1'b1, ~EXT, {24'h000000, INDEX_NONE});
      $display("Register tests done");
      // A reset in mid-run must clear the result, the table and the control word.
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(result_o, {24'h000000, INDEX_NONE});
      rstn_i <= 1'b1;
      rd(11'h394, 32'h0, RESP_OKAY);
      rd(IDX_CTRL, 32'h0, RESP_OKAY);
      frame(1'b1, EXT, {24'h000000, INDEX_NONE});
      $display("Reset test done");
      close_out();
   end
   // The tests need well under a thousand cycles; this span leaves wide margin.
   initial begin
      #100000;
      err_total++;
      close_out();
   end
endmodule
